/* src/sadc_regs.svh */
// Constants for the SAR converter control block and its host.
// Assumes a 125 MHz system clock on both ends.
// Contract
// - Start falling edge: hold input, start conversion
// - Conversion ends after 2.3 us, latch result
// - Start high at end: stay powered
// - Start low at end: latch, then power down
// - Rising start edge wakes part, 1.5 us
// - Early fall waits out power-up, then converts
// - Rising start edge enables serial output port
// - Early read shifts out previous result
// - Read in progress defers result latch
// - Read after 2.3 us gets new result
// - Serial port works while powered down
// - Auto mode: read ends before next rise
// - Rising start edge clears bit counter
// - After ten bits, ignore further serial clocks
// - Bits launched on rising serial clock edges
// - Output released on tenth falling clock edge
// - No shifting before a rising start edge
// - Continuous or burst serial clock both work
// - Host: idle-low clock, sample on falling
// - Eight-bit hosts use two back-to-back transfers
// - Power-on state is powered down, start low
// - Straight binary result, 1024 codes
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH
`define SADC_CLK_NS 8
`define SADC_T_PWRUP_NS 1500
`define SADC_T_CONV_NS 2300
`define SADC_PWRUP_CYC ((`SADC_T_PWRUP_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_CONV_CYC ((`SADC_T_CONV_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_RES_BITS 10
`define SADC_CODES 1024
`define SADC_SCLK_HALF 16
`define SADC_HOST_MARGIN 16
`endif

/* src/sadc_pkg.sv */
// Types for the SAR converter control block and its host.
// Assumes sadc_regs.svh carries the numeric constants.
package sadc_pkg;
	typedef enum logic [3:0] {
		DEV_PDOWN = 4'h1,
		DEV_PWRUP = 4'h2,
		DEV_IDLE = 4'h4,
		DEV_CONV = 4'h8
	} sadc_dev_state_t;
	typedef enum logic [3:0] {
		HST_IDLE = 4'h1,
		HST_WAKE = 4'h2,
		HST_CONV = 4'h4,
		HST_READ = 4'h8
	} sadc_host_state_t;
endpackage : sadc_pkg

/* src/sadc_if.sv */
// Three-wire link between converter and host.
// Assumes the bench joins both ends through this carrier.
`timescale 1ns/1ps
interface sadc_if;
	logic convStartN;
	logic sclk;
	logic doutO;
	logic doutOe;
	logic doutLine;
	// Undriven data line reads as low
	assign doutLine = doutOe & doutO;
	modport dev (
		input convStartN,
		input sclk,
		output doutO,
		output doutOe
	);
	modport host (
		output convStartN,
		output sclk,
		input doutLine
	);
endinterface : sadc_if

/* src/sadc_sync.sv */
// Three-flop input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/1ps
module sadc_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic asyncIn,
	output logic syncOut
);
	logic ff1_reg;
	logic ff2_reg;
	logic ff3_reg;
	logic out_reg;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ff1_reg <= RST_VAL;
			ff2_reg <= RST_VAL;
			ff3_reg <= RST_VAL;
		end else if (clkEn) begin
			ff1_reg <= asyncIn;
			ff2_reg <= ff1_reg;
			ff3_reg <= ff2_reg;
		end
	end
	// Level changes once second and third agree
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			out_reg <= RST_VAL;
		end else if (clkEn && ff2_reg == ff3_reg) begin
			out_reg <= ff3_reg;
		end
	end
	assign syncOut = out_reg;
endmodule : sadc_sync

/* src/sadc_device.sv */
// Converter end: conversion sequencing, power modes, serial readout.
// Assumes start and serial clock come from the host asynchronously.
`timescale 1ns/1ps
`include "sadc_regs.svh"
module sadc_device import sadc_pkg::*; #(
	parameter int PWRUP_CYC = `SADC_PWRUP_CYC,
	parameter int CONV_CYC = `SADC_CONV_CYC,
	parameter int RES_BITS = `SADC_RES_BITS
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clkEn,
	sadc_if.dev link,
	input wire logic [RES_BITS-1:0] analogCode,
	output logic powered,
	output logic converting,
	output logic convDone
);
	localparam int TW = 12;
	localparam int CW = $clog2(RES_BITS + 1);
	logic csLvl;
	logic sclkLvl;
	logic csPrev_reg;
	logic sclkPrev_reg;
	logic csRise;
	logic csFall;
	logic sclkRise;
	logic sclkFall;
	sadc_dev_state_t state_reg;
	sadc_dev_state_t state_next;
	logic [TW-1:0] timer_reg;
	logic startPend_reg;
	logic pwrDone;
	logic convEnd;
	logic [RES_BITS-1:0] hold_reg;
	logic [RES_BITS-1:0] outData_reg;
	logic [RES_BITS-1:0] newData_reg;
	logic latchPend_reg;
	logic [RES_BITS-1:0] shift_reg;
	logic [CW-1:0] bitCnt_reg;
	logic armed_reg;
	logic reading_reg;
	logic readEnd;
	logic firstBit;
	logic doutO_reg;
	logic doutOe_reg;
	logic powered_reg;
	logic converting_reg;
	logic convDone_reg;

	sadc_sync #(
		.RST_VAL(1'b0)
	) u_csSync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.clkEn(clkEn),
		.asyncIn(link.convStartN),
		.syncOut(csLvl)
	);
	sadc_sync #(
		.RST_VAL(1'b0)
	) u_sclkSync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.clkEn(clkEn),
		.asyncIn(link.sclk),
		.syncOut(sclkLvl)
	);

	// Edge detection on filtered levels
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			csPrev_reg <= 1'b0;
			sclkPrev_reg <= 1'b0;
		end else if (clkEn) begin
			csPrev_reg <= csLvl;
			sclkPrev_reg <= sclkLvl;
		end
	end
	assign csRise = csLvl & ~csPrev_reg;
	assign csFall = ~csLvl & csPrev_reg;
	assign sclkRise = sclkLvl & ~sclkPrev_reg;
	assign sclkFall = ~sclkLvl & sclkPrev_reg;

	assign pwrDone = (state_reg == DEV_PWRUP) && (timer_reg == TW'(PWRUP_CYC - 1));
	assign convEnd = (state_reg == DEV_CONV) && (timer_reg == TW'(CONV_CYC - 1));

	// Power and conversion sequencing
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			DEV_PDOWN: begin
				if (csRise) begin
					state_next = DEV_PWRUP;
				end
			end
			DEV_PWRUP: begin
				if (pwrDone) begin
					state_next = (startPend_reg || csFall) ? DEV_CONV : DEV_IDLE;
				end
			end
			DEV_IDLE: begin
				if (csFall) begin
					state_next = DEV_CONV;
				end
			end
			DEV_CONV: begin
				if (convEnd) begin
					state_next = csLvl ? DEV_IDLE : DEV_PDOWN;
				end
			end
			default: begin
				state_next = DEV_PDOWN;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_reg <= DEV_PDOWN;
		end else if (clkEn) begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			timer_reg <= '0;
		end else if (clkEn) begin
			timer_reg <= (state_next != state_reg) ? '0 : timer_reg + TW'(1);
		end
	end

	// Falling start edge during wake-up is remembered
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			startPend_reg <= 1'b0;
		end else if (clkEn) begin
			if (state_reg != DEV_PWRUP) begin
				startPend_reg <= 1'b0;
			end else if (csFall) begin
				startPend_reg <= 1'b1;
			end
		end
	end

	// Track and hold
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			hold_reg <= '0;
		end else if (clkEn && state_next == DEV_CONV && state_reg != DEV_CONV) begin
			hold_reg <= analogCode;
		end
	end

	assign firstBit = sclkRise && armed_reg && bitCnt_reg == '0 && !csRise;
	assign readEnd = sclkFall && armed_reg && bitCnt_reg == CW'(RES_BITS);

	// Result latch, deferred behind an active read
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			outData_reg <= '0;
			newData_reg <= '0;
			latchPend_reg <= 1'b0;
		end else if (clkEn) begin
			if (convEnd && (reading_reg || firstBit) && !readEnd) begin
				newData_reg <= hold_reg;
				latchPend_reg <= 1'b1;
			end else if (convEnd) begin
				outData_reg <= hold_reg;
				latchPend_reg <= 1'b0;
			end else if ((readEnd || csRise) && latchPend_reg) begin
				outData_reg <= newData_reg;
				latchPend_reg <= 1'b0;
			end
		end
	end

	// Serial readout, independent of power state
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			armed_reg <= 1'b0;
			bitCnt_reg <= '0;
			reading_reg <= 1'b0;
			shift_reg <= '0;
			doutO_reg <= 1'b0;
			doutOe_reg <= 1'b0;
		end else if (clkEn) begin
			if (csRise) begin
				armed_reg <= 1'b1;
				bitCnt_reg <= '0;
				reading_reg <= 1'b0;
				doutOe_reg <= 1'b0;
			end else if (sclkRise && armed_reg && bitCnt_reg < CW'(RES_BITS)) begin
				reading_reg <= 1'b1;
				doutOe_reg <= 1'b1;
				bitCnt_reg <= bitCnt_reg + CW'(1);
				if (bitCnt_reg == '0) begin
					doutO_reg <= outData_reg[RES_BITS-1];
					shift_reg <= {outData_reg[RES_BITS-2:0], 1'b0};
				end else begin
					doutO_reg <= shift_reg[RES_BITS-1];
					shift_reg <= {shift_reg[RES_BITS-2:0], 1'b0};
				end
			end else if (readEnd) begin
				armed_reg <= 1'b0;
				reading_reg <= 1'b0;
				doutOe_reg <= 1'b0;
				doutO_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			powered_reg <= 1'b0;
			converting_reg <= 1'b0;
			convDone_reg <= 1'b0;
		end else if (clkEn) begin
			powered_reg <= state_next != DEV_PDOWN;
			converting_reg <= state_next == DEV_CONV;
			convDone_reg <= convEnd;
		end
	end

	assign link.doutO = doutO_reg;
	assign link.doutOe = doutOe_reg;
	assign powered = powered_reg;
	assign converting = converting_reg;
	assign convDone = convDone_reg;
endmodule : sadc_device

/* src/sadc_host.sv */
// Host end: drives start and serial clock, collects ten-bit results.
// Assumes the converter end sits on the other side of sadc_if.
`timescale 1ns/1ps
`include "sadc_regs.svh"
module sadc_host import sadc_pkg::*; #(
	parameter int PWRUP_CYC = `SADC_PWRUP_CYC,
	parameter int CONV_CYC = `SADC_CONV_CYC,
	parameter int RES_BITS = `SADC_RES_BITS,
	parameter int SCLK_HALF = `SADC_SCLK_HALF,
	parameter int MARGIN = `SADC_HOST_MARGIN
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clkEn,
	sadc_if.host link,
	input wire logic startReq,
	input wire logic autoPd,
	output logic [RES_BITS-1:0] result,
	output logic resultValid,
	output logic busy
);
	localparam int TW = 12;
	localparam int CW = $clog2(RES_BITS + 1);
	sadc_host_state_t state_reg;
	logic [TW-1:0] timer_reg;
	logic autoPd_reg;
	logic reArm_reg;
	logic cs_reg;
	logic sclk_reg;
	logic [CW-1:0] bitCnt_reg;
	logic [RES_BITS-1:0] shift_reg;
	logic [RES_BITS-1:0] result_reg;
	logic valid_reg;
	logic busy_reg;
	logic doutLvl;

	sadc_sync #(
		.RST_VAL(1'b0)
	) u_doutSync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.clkEn(clkEn),
		.asyncIn(link.doutLine),
		.syncOut(doutLvl)
	);

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_reg <= HST_IDLE;
			timer_reg <= '0;
			autoPd_reg <= 1'b0;
			reArm_reg <= 1'b0;
			cs_reg <= 1'b0;
			sclk_reg <= 1'b0;
			bitCnt_reg <= '0;
			shift_reg <= '0;
			result_reg <= '0;
			valid_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else if (clkEn) begin
			valid_reg <= 1'b0;
			timer_reg <= timer_reg + TW'(1);
			case (state_reg)
				HST_IDLE: begin
					if (startReq) begin
						cs_reg <= 1'b1;
						busy_reg <= 1'b1;
						autoPd_reg <= autoPd;
						reArm_reg <= cs_reg;
						timer_reg <= '0;
						state_reg <= HST_WAKE;
					end
				end
				HST_WAKE: begin
					if (timer_reg == TW'(PWRUP_CYC - 1)) begin
						cs_reg <= 1'b0;
						timer_reg <= '0;
						state_reg <= HST_CONV;
					end
				end
				HST_CONV: begin
					// Start left high: pulse it in auto mode to re-arm the port, else raise and hold it
					if (timer_reg == TW'(MARGIN) && (!autoPd_reg || reArm_reg)) begin
						cs_reg <= 1'b1;
					end
					if (timer_reg == TW'(2 * MARGIN) && autoPd_reg && reArm_reg) begin
						cs_reg <= 1'b0;
					end
					if (timer_reg == TW'(CONV_CYC + MARGIN)) begin
						timer_reg <= '0;
						bitCnt_reg <= '0;
						state_reg <= HST_READ;
					end
				end
				HST_READ: begin
					// Idle-low clock, data taken on falling edge
					if (timer_reg == TW'(SCLK_HALF - 1)) begin
						timer_reg <= '0;
						sclk_reg <= ~sclk_reg;
						if (sclk_reg) begin
							shift_reg <= {shift_reg[RES_BITS-2:0], doutLvl};
							bitCnt_reg <= bitCnt_reg + CW'(1);
							if (bitCnt_reg == CW'(RES_BITS - 1)) begin
								result_reg <= {shift_reg[RES_BITS-2:0], doutLvl};
								valid_reg <= 1'b1;
								busy_reg <= 1'b0;
								state_reg <= HST_IDLE;
							end
						end
					end
				end
				default: begin
					state_reg <= HST_IDLE;
				end
			endcase
		end
	end

	assign link.convStartN = cs_reg;
	assign link.sclk = sclk_reg;
	assign result = result_reg;
	assign resultValid = valid_reg;
	assign busy = busy_reg;
endmodule : sadc_host

/* dv/sadc_link_checker.sv */
// Checker on the three-wire link between converter and host.
// Assumes the bench instantiates it beside sadc_if.
`timescale 1ns/1ps
`include "sadc_regs.svh"
module sadc_link_checker #(
	parameter int CONV_CYC = `SADC_CONV_CYC
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic convStartN,
	input wire logic sclk,
	input wire logic doutO,
	input wire logic doutOe
);
	logic [3:0] fallCnt_reg;
	logic [15:0] sinceFall_reg;
	logic sclkPrev_reg;
	logic startPrev_reg;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clk_sys) begin
		sclkPrev_reg <= sclk;
		startPrev_reg <= convStartN;
	end
	// Serial clock falls since last start rise
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			fallCnt_reg <= 4'hA;
		end else if (convStartN && !startPrev_reg) begin
			fallCnt_reg <= 4'h0;
		end else if (sclkPrev_reg && !sclk && fallCnt_reg < 4'hA) begin
			fallCnt_reg <= fallCnt_reg + 4'h1;
		end
	end
	// Cycles since last start fall
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sinceFall_reg <= 16'h0000;
		end else if (!convStartN && startPrev_reg) begin
			sinceFall_reg <= 16'h0001;
		end else if (sinceFall_reg != 16'hFFFF) begin
			sinceFall_reg <= sinceFall_reg + 16'h0001;
		end
	end
	sequence tenthFall;
		$fell(sclk) && fallCnt_reg == 4'h9;
	endsequence
	sequence readStart;
		$rose(sclk) && fallCnt_reg == 4'h0;
	endsequence
	AST_QUIET_AFTER_RESET: assert property ($rose(rstn) |-> !doutOe && !sclk)
		else $error("link active right after reset");
	AST_ARMED_ONLY: assert property ($rose(doutOe) |-> fallCnt_reg < 4'hA)
		else $error("data driven without armed counter");
	AST_LAUNCH_ON_RISE: assert property ($rose(doutOe) |-> sclk)
		else $error("first bit not launched on rising clock");
	AST_BIT_ON_RISE: assert property (($changed(doutO) && doutOe && $past(doutOe)) |-> sclk)
		else $error("data changed outside rising clock phase");
	AST_TENTH_RELEASE: assert property (tenthFall |-> ##[1:10] !doutOe)
		else $error("data not released after tenth fall");
	AST_RELEASE_ON_FALL: assert property ($fell(doutOe) |-> !sclk)
		else $error("data released outside falling clock phase");
	AST_STAY_RELEASED: assert property ((fallCnt_reg == 4'hA) [*8] |-> !doutOe)
		else $error("data driven after ten bits");
	AST_IDLE_LOW: assert property (fallCnt_reg == 4'hA |-> !sclk)
		else $error("serial clock not idle low");
	AST_NO_READ_ACROSS_RISE: assert property ($rose(convStartN) |->
		(fallCnt_reg == 4'hA || (fallCnt_reg == 4'h0 && !sclk)))
		else $error("read crosses start rise");
	AST_READ_AFTER_CONV: assert property (readStart |-> sinceFall_reg >= CONV_CYC)
		else $error("read started before conversion end");
endmodule : sadc_link_checker

/* dv/tb.sv */
// Testbench joining converter and host ends through sadc_if.
// Assumes default parameters and the 125 MHz system clock.
`timescale 1ns/1ps
`include "sadc_regs.svh"
module tb;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic clkEn = 1'b1;
	logic startReq = 1'b0;
	logic autoPd = 1'b0;
	logic [9:0] analogCode = 10'h000;
	logic [9:0] result;
	logic resultValid, busy, powered, converting, convDone;
	int errTotal = 0;
	int nTests = 0;
	int doneCnt = 0;
	sadc_if link ();
	sadc_device u_sadc_device (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .link(link.dev),
		.analogCode(analogCode), .powered(powered), .converting(converting), .convDone(convDone));
	sadc_host u_sadc_host (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .link(link.host),
		.startReq(startReq), .autoPd(autoPd), .result(result), .resultValid(resultValid), .busy(busy));
	sadc_link_checker u_sadc_link_checker (.clk_sys(clk_sys), .rstn(rstn), .convStartN(link.convStartN),
		.sclk(link.sclk), .doutO(link.doutO), .doutOe(link.doutOe));
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (convDone === 1'b1) doneCnt++;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		nTests++;
		if (seen !== exp) begin
			errTotal++;
			$display("MISMATCH %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask : step
	task automatic endOfTest();
		if (errTotal == 0 && nTests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : endOfTest
	// One host request, timing and result judged
	task automatic runOp(input logic [9:0] code, input logic ap, input bit frz);
		int n;
		int d0;
		analogCode = code;
		autoPd = ap;
		d0 = doneCnt;
		startReq = 1'b1;
		step();
		startReq = 1'b0;
		n = 0;
		while (converting !== 1'b1 && n < 400) begin
			step();
			n++;
		end
		chk(16'(n >= `SADC_PWRUP_CYC && n <= `SADC_PWRUP_CYC + 24), 16'h0001);
		analogCode = ~code;
		n = 0;
		while (converting === 1'b1 && n < 400) begin
			step();
			n++;
		end
		chk(16'(n >= `SADC_CONV_CYC && n <= `SADC_CONV_CYC + 2), 16'h0001);
		if (frz) begin
			repeat (100) step();
			clkEn = 1'b0;
			repeat (40) step();
			clkEn = 1'b1;
		end
		n = 0;
		while (resultValid !== 1'b1 && n < 2000) begin
			step();
			n++;
		end
		chk({6'h00, result}, {6'h00, code});
		chk({15'h0000, powered}, {15'h0000, ~ap});
		chk(16'(doneCnt - d0), 16'h0001);
	endtask : runOp
	task automatic sReset();
		chk({11'h000, link.convStartN, powered, converting, busy, link.doutOe}, 16'h0000);
	endtask : sReset
	task automatic sCodes();
		logic [9:0] codes [5] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA, 10'h201};
		foreach (codes[i]) runOp(codes[i], 1'b1, 1'b0);
	endtask : sCodes
	task automatic sSpeed();
		runOp(10'h2AA, 1'b0, 1'b0);
		runOp(10'h0F0, 1'b1, 1'b0);
	endtask : sSpeed
	task automatic sBurst();
		runOp(10'h133, 1'b1, 1'b1);
	endtask : sBurst
	task automatic sMidReset();
		startReq = 1'b1;
		step();
		startReq = 1'b0;
		repeat (250) step();
		rstn = 1'b0;
		repeat (2) step();
		chk({11'h000, link.convStartN, powered, converting, busy, link.doutOe}, 16'h0000);
		rstn = 1'b1;
		step();
		runOp(10'h3C5, 1'b1, 1'b0);
	endtask : sMidReset
	initial begin
		repeat (20000) @(posedge clk_sys);
		errTotal++;
		endOfTest();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		#1;
		rstn = 1'b1;
		step();
		sReset();
		sCodes();
		sSpeed();
		sBurst();
		sMidReset();
		endOfTest();
	end
endmodule : tb
